// ==== src/cce_core.sv ====
// Purpose: Executes clear, call, watchdog clear, complement and decrement instructions.
// Assumes: Decoded op arrives with operands; file register 3 is the status register.
// Notes: Instructions are accepted on ISSUE when READY is high.
//
// Contract
// - Clear accumulator loads zero, sets zero flag
// - Call pushes PC plus one first
// - Call loads eight-bit target into PC low
// - Call copies status 6:5, clears PC bit 8
// - Call takes two cycles, flags unchanged
// - Watchdog clear zeroes counter, sets both flags
// - Prescaler cleared only when assigned to watchdog
// - Clear file zeroes register, sets zero flag
// - Complement inverts register, updates zero flag
// - Destination bit selects accumulator or file
// - Decrement subtracts one, updates zero flag
// - Decrement-skip stores result, flags unchanged
// - Zero decrement-skip result inserts one no-operation
`timescale 1ns/100ps
`default_nettype none
module cce_core
   import cce_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic ISSUE,
   input wire logic [2:0] OPCODE,
   input wire logic [4:0] FILE_ADDR,
   input wire logic DEST,
   input wire logic [7:0] TARGET,
   input wire logic PSA_WDT,
   output logic READY,
   output logic [10:0] PC,
   output logic [7:0] ACC,
   output logic [7:0] STATUS,
   output logic PUSH,
   output logic [10:0] PUSH_DATA,
   output logic FILE_WE,
   output logic [4:0] FILE_WADDR,
   output logic [7:0] FILE_WDATA,
   output logic [7:0] FILE_RDATA,
   output logic WDT_CLEAR,
   output logic PRESCALER_CLEAR
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      cce_state_t fsm;
      logic ready;
      logic [10:0] pc;
      logic [7:0] acc;
      logic [7:0] status;
      logic push;
      logic [10:0] push_data;
      logic file_we;
      logic [4:0] file_waddr;
      logic [7:0] file_wdata;
      logic [7:0] file_rdata;
   } cce_core_st_t;

   cce_core_st_t st, next_st;
   // File registers other than status live here; one array, written in the same struct style
   // would bloat the state vector, so it is kept as a separate register bank.
   logic [7:0] files [0:31];
   cce_alu_if alu_bus();
   logic fire;
   logic wd_fire;
   logic [7:0] operand;
   cce_op_t op_dec;

   function automatic logic [10:0] pc_inc(input logic [10:0] p);
      return 11'(p + 11'h001);
   endfunction

   cce_alu u_alu (.bus(alu_bus.alu));

   cce_wdt_clear u_wdt (
      .clk(CLOCK),
      .rst_n(RESETN),
      .ce(CE),
      .fire(wd_fire),
      .psa_wdt(PSA_WDT),
      .wdt_clr(WDT_CLEAR),
      .pre_clr(PRESCALER_CLEAR)
   );

   // ------------------------------------------------------------
   // Operand fetch and execution
   // ------------------------------------------------------------
   assign fire = ISSUE && (st.fsm == CCE_ST_EXEC);
   assign wd_fire = fire && (cce_op_t'(OPCODE) == CCE_OP_CLRWD);
   assign operand = (FILE_ADDR == FADDR_STATUS) ? st.status : files[FILE_ADDR];
   assign op_dec = cce_op_t'(OPCODE);
   assign alu_bus.op = op_dec;
   assign alu_bus.operand = operand;

   always_comb begin
      next_st = st;
      if (CE) begin
         next_st.push = 1'b0;
         next_st.file_we = 1'b0;
         if (st.fsm == CCE_ST_STALL) begin
            // The second cycle of a call or taken skip runs as a no-operation.
            next_st.fsm = CCE_ST_EXEC;
            // A call still shows its push pulse here; a skip steps past the discarded word.
            if (!st.push) begin
               next_st.pc = pc_inc(st.pc);
            end
         end else if (ISSUE) begin
            next_st.file_rdata = operand;
            next_st.pc = pc_inc(st.pc);
            unique case (cce_op_t'(OPCODE))
               CCE_OP_NOP: begin
               end
               CCE_OP_CLRACC: begin
                  next_st.acc = ZERO_BYTE;
                  next_st.status[STAT_Z] = 1'b1;
               end
               CCE_OP_CALL: begin
                  next_st.push = 1'b1;
                  next_st.push_data = pc_inc(st.pc);
                  next_st.pc = {st.status[STAT_PAGE_HI:STAT_PAGE_LO], 1'b0, TARGET};
                  next_st.fsm = CCE_ST_STALL;
               end
               CCE_OP_CLRWD: begin
                  next_st.status[STAT_TO] = 1'b1;
                  next_st.status[STAT_PD] = 1'b1;
               end
               CCE_OP_CLEAR_FILE_OP: begin
                  next_st.file_we = 1'b1;
                  next_st.file_waddr = FILE_ADDR;
                  next_st.file_wdata = ZERO_BYTE;
                  next_st.status[STAT_Z] = 1'b1;
                  if (FILE_ADDR == FADDR_STATUS) begin
                     next_st.status = ZERO_BYTE;
                     next_st.status[STAT_Z] = 1'b1;
                  end
               end
               CCE_OP_COMPLEMENT_FILE_OP, CCE_OP_DECREMENT_FILE_OP, CCE_OP_DECSKIP: begin
                  if (DEST) begin
                     next_st.file_we = 1'b1;
                     next_st.file_waddr = FILE_ADDR;
                     next_st.file_wdata = alu_bus.result;
                     if (FILE_ADDR == FADDR_STATUS) begin
                        next_st.status = alu_bus.result;
                     end
                  end else begin
                     next_st.acc = alu_bus.result;
                  end
                  if (cce_op_t'(OPCODE) != CCE_OP_DECSKIP) begin
                     next_st.status[STAT_Z] = alu_bus.zero;
                  end else if (alu_bus.zero) begin
                     next_st.fsm = CCE_ST_STALL;
                  end
               end
            endcase
         end
         // READY has a flop of its own so that the output needs no decode after the register.
         next_st.ready = (next_st.fsm == CCE_ST_EXEC);
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         st <= '{fsm: CCE_ST_EXEC, ready: 1'b1, pc: PC_RESET, acc: W_RESET, status: STATUS_RESET,
                 push: 1'b0, push_data: '0, file_we: 1'b0, file_waddr: '0,
                 file_wdata: '0, file_rdata: '0};
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (CE && fire && (cce_op_t'(OPCODE) == CCE_OP_CLEAR_FILE_OP
            || (DEST && (cce_op_t'(OPCODE) == CCE_OP_COMPLEMENT_FILE_OP || cce_op_t'(OPCODE) == CCE_OP_DECREMENT_FILE_OP
            || cce_op_t'(OPCODE) == CCE_OP_DECSKIP)))) begin
         files[FILE_ADDR] <= alu_bus.result;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign READY = st.ready;
   assign PC = st.pc;
   assign ACC = st.acc;
   assign STATUS = st.status;
   assign PUSH = st.push;
   assign PUSH_DATA = st.push_data;
   assign FILE_WE = st.file_we;
   assign FILE_WADDR = st.file_waddr;
   assign FILE_WDATA = st.file_wdata;
   assign FILE_RDATA = st.file_rdata;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_call_issued;
      CE && fire && cce_op_t'(OPCODE) == CCE_OP_CALL;
   endsequence
   sequence s_call_stall;
      !READY && CE ##1 READY;
   endsequence

   // A skip is taken when the operand is one, since the decrement then lands on zero.
   sequence s_skip_taken;
      CE && fire && op_dec == CCE_OP_DECSKIP && operand == 8'h01;
   endsequence
   sequence s_plain_issued;
      CE && fire && op_dec != CCE_OP_CALL && op_dec != CCE_OP_DECSKIP;
   endsequence
   sequence s_to_file;
      CE && fire && DEST && FILE_ADDR != FADDR_STATUS
         && op_dec inside {CCE_OP_COMPLEMENT_FILE_OP, CCE_OP_DECREMENT_FILE_OP, CCE_OP_DECSKIP};
   endsequence

   chk_clracc_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_CLRACC) |=> (ACC == 8'h00 && STATUS[2]))
      else $error("clear accumulator wrong");
   chk_call_push: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_call_issued |=> (PUSH && PUSH_DATA == pc_inc($past(PC))))
      else $error("call push wrong");
   chk_call_target: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_call_issued |=> (PC[7:0] == $past(TARGET) && !PC[8]
         && PC[10:9] == $past(STATUS[6:5]))) else $error("call target wrong");
   chk_call_page: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_call_issued |=> PC[10:9] == $past(STATUS[6:5])) else $error("call page wrong");
   chk_call_cycles: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_call_issued |=> s_call_stall) else $error("call not two cycles");
   chk_call_flags: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_call_issued |=> $stable(STATUS)) else $error("call changed flags");
   chk_wd_flags: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && wd_fire) |=> (STATUS[4] && STATUS[3])) else $error("watchdog flags not set");
   chk_clear_file_op_write: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_CLEAR_FILE_OP)
      |=> (FILE_WE && FILE_WDATA == 8'h00 && STATUS[2])) else $error("clear file wrong");
   chk_complement_file_op_value: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_COMPLEMENT_FILE_OP && !DEST && FILE_ADDR != 5'h03)
      |=> ACC == ~FILE_RDATA) else $error("complement wrong");
   chk_dest_file: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_DECREMENT_FILE_OP && DEST)
      |=> (FILE_WE && $stable(ACC))) else $error("destination routing wrong");
   chk_dec_value: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_DECREMENT_FILE_OP && !DEST && FILE_ADDR != 5'h03)
      |=> (ACC == 8'(FILE_RDATA - 8'h01) && STATUS[2] == (ACC == 8'h00)))
      else $error("decrement wrong");
   chk_decskip_flags: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_DECSKIP && FILE_ADDR != 5'h03)
      |=> $stable(STATUS)) else $error("skip changed flags");
   chk_skip_taken: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_DECSKIP && operand == 8'h01)
      |=> !READY) else $error("skip not taken");
   chk_single_cycle: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && cce_op_t'(OPCODE) == CCE_OP_DECREMENT_FILE_OP)
      |=> (READY && PC == pc_inc($past(PC)))) else $error("plain op not one cycle");

   // Pulse lengths, the no-operation cycle and the clock enable freeze are watched here.
   chk_push_pulse: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (PUSH && CE) |=> !PUSH)
      else $error("push pulse too long");
   chk_call_ready: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (!READY && CE) |=> (READY && !PUSH && !FILE_WE))
      else $error("no-operation cycle wrong");
   chk_skip_resume: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_skip_taken ##1 CE |=> (READY && PC == pc_inc(pc_inc($past(PC, 2)))))
      else $error("skip did not step past");
   chk_skip_not_taken: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && op_dec == CCE_OP_DECSKIP && operand != 8'h01)
      |=> (READY && PC == pc_inc($past(PC)))) else $error("skip taken wrongly");
   chk_plain_one_cycle: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_plain_issued |=> (READY && PC == pc_inc($past(PC))))
      else $error("plain op pc wrong");
   chk_clear_file_op_addr: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && op_dec == CCE_OP_CLEAR_FILE_OP) |=> FILE_WADDR == $past(FILE_ADDR))
      else $error("clear file address wrong");
   chk_file_write: assert property (@(posedge CLOCK) disable iff (!RESETN)
      s_to_file |=> (FILE_WE && FILE_WADDR == $past(FILE_ADDR) && $stable(ACC)))
      else $error("file write routing wrong");
   chk_acc_dest: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && !DEST && op_dec inside {CCE_OP_COMPLEMENT_FILE_OP, CCE_OP_DECREMENT_FILE_OP, CCE_OP_DECSKIP})
      |=> !FILE_WE) else $error("accumulator routing wrote file");
   chk_complement_file_op_file: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && op_dec == CCE_OP_COMPLEMENT_FILE_OP && DEST && FILE_ADDR != FADDR_STATUS)
      |=> (FILE_WDATA == ~FILE_RDATA && STATUS[STAT_Z] == (FILE_WDATA == ZERO_BYTE)))
      else $error("complement to file wrong");
   chk_complement_file_op_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && op_dec == CCE_OP_COMPLEMENT_FILE_OP && !DEST && FILE_ADDR != FADDR_STATUS)
      |=> STATUS[STAT_Z] == (ACC == ZERO_BYTE)) else $error("complement zero flag wrong");
   chk_decskip_store: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && op_dec == CCE_OP_DECSKIP && DEST && FILE_ADDR != FADDR_STATUS)
      |=> FILE_WDATA == 8'(FILE_RDATA - 8'h01)) else $error("skip store wrong");
   chk_decskip_acc: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (CE && fire && op_dec == CCE_OP_DECSKIP && !DEST)
      |=> ACC == 8'(FILE_RDATA - 8'h01)) else $error("skip result to accumulator wrong");
   chk_wdt_pulse: assert property (@(posedge CLOCK) disable iff (!RESETN)
      (WDT_CLEAR && CE && !wd_fire) |=> !WDT_CLEAR)
      else $error("watchdog clear pulse too long");
   chk_ce_freeze: assert property (@(posedge CLOCK) disable iff (!RESETN)
      !CE |=> ($stable(PC) && $stable(ACC) && $stable(STATUS) && $stable(READY)))
      else $error("state moved while clock enable low");
endmodule // cce_core
`default_nettype wire

// ==== shared/cce_pkg.sv ====
// Purpose: Shared constants and types for the clear/call/decrement execution block.
// Assumes: 8-bit data, 11-bit program counter, 32 file registers.
// Notes: Opcode codes are a local encoding chosen for this block.
package cce_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int FADDR_W = 5;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [10:0] PC_RESET = 11'h7_FF;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam int STAT_Z = 2;
   localparam int STAT_PD = 3;
   localparam int STAT_TO = 4;
   localparam int STAT_PAGE_LO = 5;
   localparam int STAT_PAGE_HI = 6;
   localparam int PC_BIT8 = 8;
   localparam logic [4:0] FADDR_STATUS = 5'h03;
   localparam int CALL_CYCLES = 2;
   localparam int SKIP_CYCLES = 2;
   localparam int PLAIN_CYCLES = 1;

   typedef enum logic [2:0] {
      CCE_OP_NOP = 3'h0,
      CCE_OP_CLRACC = 3'h1,
      CCE_OP_CALL = 3'h2,
      CCE_OP_CLRWD = 3'h3,
      CCE_OP_CLEAR_FILE_OP = 3'h4,
      CCE_OP_COMPLEMENT_FILE_OP = 3'h5,
      CCE_OP_DECREMENT_FILE_OP = 3'h6,
      CCE_OP_DECSKIP = 3'h7
   } cce_op_t;

   typedef enum {CCE_ST_EXEC, CCE_ST_STALL} cce_state_t;
endpackage

// ==== shared/cce_alu_if.sv ====
// Purpose: Carries operand and result between the core and its ALU.
// Assumes: One clock; purely combinational exchange.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
interface cce_alu_if;
   import cce_pkg::*;
   cce_op_t op;
   logic [7:0] operand;
   logic [7:0] result;
   logic zero;
   modport core (output op, output operand, input result, input zero);
   modport alu (input op, input operand, output result, output zero);
endinterface
`default_nettype wire

// ==== src/cce_alu.sv ====
// Purpose: Computes the byte result of the clear, complement and decrement operations.
// Assumes: Operand is the addressed file register.
// Notes: Zero output is taken from the result.
`timescale 1ns/100ps
`default_nettype none
module cce_alu
   import cce_pkg::*;
(
   cce_alu_if.alu bus
);
   function automatic logic [7:0] dec_byte(input logic [7:0] v);
      return 8'(v - 8'h01);
   endfunction

   always_comb begin
      unique case (bus.op)
         CCE_OP_COMPLEMENT_FILE_OP: bus.result = ~bus.operand;
         CCE_OP_DECREMENT_FILE_OP, CCE_OP_DECSKIP: bus.result = dec_byte(bus.operand);
         default: bus.result = ZERO_BYTE;
      endcase
      bus.zero = (bus.result == ZERO_BYTE);
   end
endmodule // cce_alu
`default_nettype wire

// ==== src/cce_wdt_clear.sv ====
// Purpose: Turns a watchdog clear into clear strobes for the counter and prescaler.
// Assumes: Prescaler assignment is a level from the core clock domain.
// Notes: Strobes are registered one cycle after the instruction.
`timescale 1ns/100ps
`default_nettype none
module cce_wdt_clear
   import cce_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic fire,
   input wire logic psa_wdt,
   output logic wdt_clr,
   output logic pre_clr
);
   typedef struct packed {
      logic wdt_clr;
      logic pre_clr;
   } cce_wst_t;
   cce_wst_t st, next_st;

   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.wdt_clr = fire;
         next_st.pre_clr = fire && psa_wdt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wdt_clr = st.wdt_clr;
   assign pre_clr = st.pre_clr;

   chk_prescaler_kept: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && fire && !psa_wdt) |=> !pre_clr) else $error("prescaler cleared while with timer");
   chk_wdt_cleared: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && fire) |=> wdt_clr) else $error("watchdog clear strobe missing");
endmodule // cce_wdt_clear
`default_nettype wire

// ==== tb/tb_clear_call_decrement_exec.sv ====
// Purpose: Self-checking bench for the clear, call, watchdog clear and decrement core.
// Assumes: File register 3 is the status register; the other file bytes start unknown.
// Notes: A reference model tracks PC, ACC, STATUS and the file bank per taken instruction.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   n_compared++; \
   if ((ex) !== (got)) begin \
      n_fail++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end \
end
module tb_clear_call_decrement_exec
   import cce_pkg::*;
;
   logic CLOCK = 1'b0, RESETN = 1'b0, CE = 1'b0, ISSUE = 1'b0, DEST = 1'b0, PSA_WDT = 1'b0;
   logic [2:0] OPCODE = 3'h0;
   logic [4:0] FILE_ADDR = 5'h00;
   logic [7:0] TARGET = 8'h00;
   logic READY, PUSH, FILE_WE, WDT_CLEAR, PRESCALER_CLEAR;
   logic [10:0] PC, PUSH_DATA;
   logic [7:0] ACC, STATUS, FILE_WDATA, FILE_RDATA;
   logic [4:0] FILE_WADDR;
   int n_fail = 0;
   int n_compared = 0;
   bit run = 1'b0;
   bit pend = 1'b0;
   logic [10:0] m_pc = PC_RESET, exp_pushd;
   logic [7:0] m_acc = W_RESET, m_stat = STATUS_RESET, exp_wd, exp_rd;
   logic [7:0] m_file [32];
   logic [4:0] exp_wa;
   logic exp_ready, exp_push = 1'b0, exp_we = 1'b0, exp_wdt = 1'b0, exp_pre = 1'b0;
   logic exp_rd_ok = 1'b0;

   cce_core dut (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .ISSUE(ISSUE), .OPCODE(OPCODE),
      .FILE_ADDR(FILE_ADDR), .DEST(DEST), .TARGET(TARGET), .PSA_WDT(PSA_WDT), .READY(READY),
      .PC(PC), .ACC(ACC), .STATUS(STATUS), .PUSH(PUSH), .PUSH_DATA(PUSH_DATA),
      .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
      .FILE_RDATA(FILE_RDATA), .WDT_CLEAR(WDT_CLEAR), .PRESCALER_CLEAR(PRESCALER_CLEAR));

   always #4 CLOCK = ~CLOCK;

   function automatic logic [7:0] exp_result(input logic [2:0] op, input logic [7:0] v);
      return (op == CCE_OP_COMPLEMENT_FILE_OP) ? ~v : 8'(v - 8'h01);
   endfunction

   // ------------------------------------------------------------
   // Issue one instruction and advance the reference model
   // ------------------------------------------------------------
   // The next call may drive new operands at the taking edge, so nothing is lowered here.
   task automatic exec(input logic [2:0] op, input logic [4:0] fa, input logic d,
                       input logic [7:0] tg, input logic psa);
      logic tk;
      logic wr;
      logic [7:0] opnd;
      logic [7:0] res;
      OPCODE <= op;
      FILE_ADDR <= fa;
      DEST <= d;
      TARGET <= tg;
      PSA_WDT <= psa;
      ISSUE <= 1'b1;
      do begin
         @(negedge CLOCK);
         tk = (CE === 1'b1) && (READY === 1'b1);
         @(posedge CLOCK);
         if (!tk) CE <= ($urandom % 4) != 0;
      end while (!tk);
      wr = 1'b0;
      res = 8'h00;
      exp_push = 1'b0;
      exp_ready = 1'b1;
      exp_rd_ok = 1'b0;
      exp_wdt = (op == CCE_OP_CLRWD);
      exp_pre = (op == CCE_OP_CLRWD) && psa;
      opnd = (fa == FADDR_STATUS) ? m_stat : m_file[fa];
      exp_rd = opnd;
      case (op)
         CCE_OP_CLRACC: begin
            m_acc = 8'h00;
            m_stat[STAT_Z] = 1'b1;
         end
         CCE_OP_CALL: begin
            exp_push = 1'b1;
            exp_pushd = m_pc + 11'h001;
            exp_ready = 1'b0;
         end
         CCE_OP_CLRWD: begin
            m_stat[STAT_TO] = 1'b1;
            m_stat[STAT_PD] = 1'b1;
         end
         CCE_OP_CLEAR_FILE_OP: begin
            wr = 1'b1;
            m_stat[STAT_Z] = 1'b1;
         end
         default: begin
            if (op != CCE_OP_NOP) begin
               exp_rd_ok = 1'b1;
               res = exp_result(op, opnd);
               wr = d;
               if (!d) m_acc = res;
               if (op != CCE_OP_DECSKIP) m_stat[STAT_Z] = (res == 8'h00);
               if (op == CCE_OP_DECSKIP && res == 8'h00) exp_ready = 1'b0;
            end
         end
      endcase
      exp_we = wr;
      exp_wa = fa;
      exp_wd = res;
      if (wr && fa == FADDR_STATUS) m_stat = res;
      else if (wr) m_file[fa] = res;
      if (op == CCE_OP_CALL) m_pc = {m_stat[STAT_PAGE_HI], m_stat[STAT_PAGE_LO], 1'b0, tg};
      else if (op == CCE_OP_DECSKIP && !exp_ready) m_pc = m_pc + 11'h002;
      else m_pc = m_pc + 11'h001;
      pend = 1'b1;
   endtask

   // ------------------------------------------------------------
   // Output comparison, once per cycle on the falling edge
   // ------------------------------------------------------------
   always @(negedge CLOCK) begin
      if (run) begin
         `CHK("acc", m_acc, ACC)
         `CHK("status", m_stat, STATUS)
         if (READY === 1'b1) `CHK("pc", m_pc, PC)
         if (pend) `CHK("ready", exp_ready, READY)
         `CHK("push", exp_push, PUSH)
         if (exp_push) `CHK("push data", exp_pushd, PUSH_DATA)
         `CHK("file we", exp_we, FILE_WE)
         if (exp_we) `CHK("file waddr", exp_wa, FILE_WADDR)
         if (exp_we) `CHK("file wdata", exp_wd, FILE_WDATA)
         if (exp_rd_ok) `CHK("file rdata", exp_rd, FILE_RDATA)
         `CHK("wdt clear", exp_wdt, WDT_CLEAR)
         `CHK("prescaler clear", exp_pre, PRESCALER_CLEAR)
         pend = 1'b0;
         exp_push = 1'b0;
         exp_we = 1'b0;
         exp_wdt = 1'b0;
         exp_pre = 1'b0;
         exp_rd_ok = 1'b0;
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang would stall on READY; the whole run needs well under this span.
   initial begin
      repeat (6000) @(posedge CLOCK);
      n_fail++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      logic [4:0] fa;
      void'($urandom(32'hc27b));
      repeat (3) @(posedge CLOCK);
      RESETN <= 1'b1;
      CE <= 1'b1;
      run = 1'b1;
      // The first call wraps the return address from the top of program space.
      exec(CCE_OP_CALL, 5'h00, 1'b0, 8'hFF, 1'b0);
      exec(CCE_OP_CALL, 5'h00, 1'b0, 8'h00, 1'b0);
      $display("test call_wrap done");
      // Counting the status byte down reaches zero on the 24th step, then wraps to all ones.
      for (int i = 0; i < 25; i++) exec(CCE_OP_DECSKIP, FADDR_STATUS, 1'b1, 8'h00, 1'b0);
      exec(CCE_OP_CALL, 5'h00, 1'b0, 8'h5A, 1'b0);
      $display("test page_skip done");
      for (int a = 0; a < 32; a++) begin
         if (a != 3) exec(CCE_OP_CLEAR_FILE_OP, 5'(a), 1'b0, 8'h00, 1'b0);
      end
      exec(CCE_OP_CLRACC, 5'h00, 1'b0, 8'h00, 1'b0);
      exec(CCE_OP_CLRWD, 5'h00, 1'b0, 8'h00, 1'b1);
      exec(CCE_OP_CLRWD, 5'h00, 1'b0, 8'h00, 1'b0);
      $display("test clear_ops done");
      exec(CCE_OP_DECREMENT_FILE_OP, 5'h08, 1'b1, 8'h00, 1'b0);
      exec(CCE_OP_DECREMENT_FILE_OP, 5'h08, 1'b1, 8'h00, 1'b0);
      exec(CCE_OP_COMPLEMENT_FILE_OP, 5'h08, 1'b1, 8'h00, 1'b0);
      exec(CCE_OP_DECSKIP, 5'h08, 1'b0, 8'h00, 1'b0);
      exec(CCE_OP_DECSKIP, 5'h08, 1'b1, 8'h00, 1'b0);
      exec(CCE_OP_DECSKIP, 5'h08, 1'b0, 8'h00, 1'b0);
      $display("test skip_corner done");
      for (int i = 0; i < 500; i++) begin
         fa = 5'($urandom);
         if (fa == FADDR_STATUS) fa = 5'h04;
         exec(3'($urandom), fa, 1'($urandom), 8'($urandom), 1'($urandom));
      end
      $display("test random_mix done");
      ISSUE <= 1'b0;
      repeat (4) @(posedge CLOCK);
      tally_and_finish();
   end
endmodule // tb_clear_call_decrement_exec
`default_nettype wire
